// ===== include/atc_pkg.sv
// Purpose: Constants, types and shared functions of the auxiliary timer.
// Assumes: One clock, registers reached over APB with 32-bit data.
// Notes: Control words keep the 16-bit layout software sees.
//
// What this block does
// - core timer/gated prescaler 8..1014, 4..512 fast
// - core counter mode rising, falling, both edges
// - core counter select 000 disables; 1XX forbidden
// - core incremental mode edge selection
// - aux mode field bits 5..3 selects mode
// - aux select bits 2..0 meaning depends mode
// - aux counts only while its run bit set, or the core run bit if remote
// - software direction bit: zero up, one down
// - bit 8 selects external direction line
// - one pin feeds three timer inputs
// - remote bit makes core run bit govern
// - bits 11..10 read zero, writes ignored
// - edge flag sticky on accepted count edge
// - direction change flag sticky on reversal
// - bit 14 shows current count direction
// - interrupt request only while enable set
// - aux prescaler same as core timer
// - aux counter select x00 disables, edges on input
// - aux counter selects 101..111 use toggle latch edges
// - aux incremental mode edge selection
// - fast bit sets input sampling rate
// - toggle latch inverts on core over/underflow
package atc_pkg;

    localparam int ATC_AW = 4;
    localparam int ATC_CNT_W = 16;
    localparam int ATC_PRE_W = 10;

    // Register byte offsets on the bus.
    localparam logic [3:0] ATC_OFF_AUX_CTRL = 4'h0;
    localparam logic [3:0] ATC_OFF_CORE_CTRL = 4'h4;
    localparam logic [3:0] ATC_OFF_AUX_CNT = 4'h8;
    localparam logic [3:0] ATC_OFF_CORE_CNT = 4'hC;

    localparam logic [15:0] ATC_CTRL_RESET = 16'h0000;
    localparam logic [15:0] ATC_CNT_RESET = 16'h0000;
    localparam logic [15:0] ATC_CNT_MAX = 16'hFFFF;
    localparam logic [15:0] ATC_CNT_MIN = 16'h0000;

    // Input sample strobe: every 8th cycle slow, every 4th fast.
    localparam logic [2:0] ATC_SAMPLE_SLOW = 3'h7;
    localparam logic [2:0] ATC_SAMPLE_FAST = 3'h3;

    typedef enum logic [2:0] {
        ATC_M_TIMER = 3'h0,
        ATC_M_COUNTER = 3'h1,
        ATC_M_GATE_LOW = 3'h2,
        ATC_M_GATE_HIGH = 3'h3,
        ATC_M_RELOAD = 3'h4,
        ATC_M_CAPTURE = 3'h5,
        ATC_M_INC_ROT = 3'h6,
        ATC_M_INC_EDGE = 3'h7
    } atc_mode_t;

    // Auxiliary control word, bit 15 first.
    typedef struct packed {
        logic irqEnable;
        logic rotDir;
        logic dirChange;
        logic edgeSeen;
        logic [1:0] rsvd;
        logic remoteRun;
        logic extDirEn;
        logic dirBit;
        logic runBit;
        atc_mode_t mode;
        logic [2:0] inSel;
    } atc_aux_ctrl_t;

    // Core control word, bit 15 first.
    typedef struct packed {
        logic [3:0] rsvd;
        logic fastMode;
        logic toggleLatch;
        logic rsvdOe;
        logic extDirEn;
        logic dirBit;
        logic runBit;
        atc_mode_t mode;
        logic [2:0] inSel;
    } atc_core_ctrl_t;

    // Writable bits of each control word; the rest read as zero, except aux bit 14.
    localparam logic [15:0] ATC_AUX_WMASK = 16'hB3FF;
    localparam logic [15:0] ATC_CORE_WMASK = 16'h0DFF;

    // Divisors 8,16,32,64,128,256,512,1014 and 4..512.
    localparam logic [9:0] ATC_DIV_SLOW [8] = '{10'h008, 10'h010,
        10'h020, 10'h040, 10'h080, 10'h100, 10'h200, 10'h3F6};
    localparam logic [9:0] ATC_DIV_FAST [8] = '{10'h004, 10'h008,
        10'h010, 10'h020, 10'h040, 10'h080, 10'h100, 10'h200};

    function automatic logic [9:0] atc_div(input logic [2:0] sel,
                                           input logic fast);
        atc_div = fast ? ATC_DIV_FAST[sel] : ATC_DIV_SLOW[sel];
    endfunction : atc_div

    // Decides whether a count step is due, given mode and selection.
    function automatic logic atc_tick(input atc_mode_t mode,
        input logic [2:0] sel, input logic pre, input logic cR,
        input logic cF, input logic dAny, input logic tR,
        input logic tF);
        logic r;
        logic f;
        r = sel[2] ? tR : cR;
        f = sel[2] ? tF : cF;
        atc_tick = 1'b0;
        unique case (mode)
            ATC_M_TIMER, ATC_M_GATE_LOW, ATC_M_GATE_HIGH: atc_tick = pre;
            ATC_M_COUNTER: begin
                unique case (sel[1:0])
                    2'h1: atc_tick = r;
                    2'h2: atc_tick = f;
                    2'h3: atc_tick = r | f;
                    default: atc_tick = 1'b0;
                endcase
            end
            ATC_M_INC_ROT, ATC_M_INC_EDGE: begin
                unique case (sel)
                    3'h1: atc_tick = cR | cF;
                    3'h2: atc_tick = dAny;
                    3'h3: atc_tick = cR | cF | dAny;
                    default: atc_tick = 1'b0;
                endcase
            end
            default: atc_tick = 1'b0;
        endcase
    endfunction : atc_tick

endpackage : atc_pkg

// ===== rtl/atc_sync_edge.sv
// Purpose: Synchronise one pin and report its sampled edges.
// Assumes: sampleEn is a one-cycle strobe in the clk_sys domain.
// Notes: Edges are one-cycle pulses aligned with the strobe.
`timescale 1ns/1ps
module atc_sync_edge (
    input wire logic clk_sys,
    input wire logic rstSyncN,
    input wire logic sampleEn,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta;
    logic stable;

    // Two flip-flops before anything looks at the pin.
    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            meta <= 1'b0;
            stable <= 1'b0;
            level <= 1'b0;
        end else begin
            meta <= pin;
            stable <= meta;
            if (sampleEn) begin
                level <= stable;
            end
        end
    end

    // Sampling slower than the clock caps the accepted input rate.
    assign rise = sampleEn & stable & ~level;
    assign fall = sampleEn & ~stable & level;
endmodule : atc_sync_edge

// ===== rtl/atc_aux_timer.sv
// Purpose: Auxiliary 16-bit timer/counter with core timer input select.
// Assumes: APB slave with zero wait states; pins are asynchronous.
// Notes: Reload and capture datapaths live outside this block.
`timescale 1ns/1ps
module atc_aux_timer
    import atc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ATC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic aux_count_in,
    input wire logic core_count_in,
    input wire logic shared_dir_pin,
    output logic t4CountIn,
    output logic coreToggleOut,
    output logic auxIrqReq
);
    logic [1:0] rstPipe;
    logic rstSyncN;
    logic [2:0] sampleCnt;
    logic sampleEn;

    atc_aux_ctrl_t auxCtrl;
    atc_core_ctrl_t coreCtrl;
    logic [ATC_CNT_W-1:0] auxCnt;
    logic [ATC_CNT_W-1:0] coreCnt;
    logic auxDirNow;
    logic auxQuadDown;
    logic coreQuadDown;
    logic tlPrev;

    logic auxLvl, auxRise, auxFall;
    logic dirLvl, dirRise, dirFall;
    logic coreLvl, coreRise, coreFall;

    // Reset is asserted at once and released through two flip-flops.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSyncN = rstPipe[1];

    // Sample strobe sets the highest input rate the timers accept.
    assign sampleEn = sampleCnt ==
        (coreCtrl.fastMode ? ATC_SAMPLE_FAST : ATC_SAMPLE_SLOW);

    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            sampleCnt <= 3'h0;
        end else begin
            sampleCnt <= sampleEn ? 3'h0 : sampleCnt + 3'h1;
        end
    end

    // Each pin is synchronised before its edges are taken.
    atc_sync_edge uAuxIn (
        .clk_sys(clk_sys),
        .rstSyncN(rstSyncN),
        .sampleEn(sampleEn),
        .pin(aux_count_in),
        .level(auxLvl),
        .rise(auxRise),
        .fall(auxFall)
    );

    // One pin drives aux direction, core direction and timer 4 input.
    atc_sync_edge uDirIn (
        .clk_sys(clk_sys),
        .rstSyncN(rstSyncN),
        .sampleEn(sampleEn),
        .pin(shared_dir_pin),
        .level(dirLvl),
        .rise(dirRise),
        .fall(dirFall)
    );

    atc_sync_edge uCoreIn (
        .clk_sys(clk_sys),
        .rstSyncN(rstSyncN),
        .sampleEn(sampleEn),
        .pin(core_count_in),
        .level(coreLvl),
        .rise(coreRise),
        .fall(coreFall)
    );

    assign t4CountIn = dirLvl;
    assign coreToggleOut = coreCtrl.toggleLatch;

    // Bus decode.
    wire apbAccess = psel & penable;
    wire apbWr = apbAccess & pwrite;
    wire hitAuxCtrl = paddr == ATC_OFF_AUX_CTRL;
    wire hitCoreCtrl = paddr == ATC_OFF_CORE_CTRL;
    wire hitAuxCnt = paddr == ATC_OFF_AUX_CNT;
    wire hitCoreCnt = paddr == ATC_OFF_CORE_CNT;
    wire hitAny = hitAuxCtrl | hitCoreCtrl | hitAuxCnt | hitCoreCnt;
    wire wrAuxCtrl = apbWr & hitAuxCtrl;
    wire wrCoreCtrl = apbWr & hitCoreCtrl;
    wire wrAuxCnt = apbWr & hitAuxCnt;
    wire wrCoreCnt = apbWr & hitCoreCnt;

    assign pready = 1'b1;
    assign pslverr = apbAccess & ~hitAny;

    // Mode classes of both timers.
    wire auxInc = auxCtrl.mode == ATC_M_INC_ROT ||
                  auxCtrl.mode == ATC_M_INC_EDGE;
    wire coreInc = coreCtrl.mode == ATC_M_INC_ROT ||
                   coreCtrl.mode == ATC_M_INC_EDGE;
    wire auxCounts = auxCtrl.mode == ATC_M_COUNTER || auxInc;
    wire coreCounts = coreCtrl.mode == ATC_M_COUNTER || coreInc;

    // Run control; remote mode hands the aux run to the core run bit.
    wire coreRunning = coreCtrl.runBit;
    wire auxRunning = auxCtrl.remoteRun ? coreCtrl.runBit
                                        : auxCtrl.runBit;

    // Gates come from each timer's own count input.
    wire auxGateOk = auxCtrl.mode == ATC_M_GATE_LOW ? ~auxLvl :
                     auxCtrl.mode == ATC_M_GATE_HIGH ? auxLvl : 1'b1;
    wire coreGateOk = coreCtrl.mode == ATC_M_GATE_LOW ? ~coreLvl :
                      coreCtrl.mode == ATC_M_GATE_HIGH ? coreLvl : 1'b1;

    // Prescalers for both timers share one structure.
    logic [ATC_PRE_W-1:0] preCnt [2];
    logic [ATC_PRE_W-1:0] preDiv [2];
    logic [1:0] preEn;
    logic [1:0] preTick;

    assign preDiv[0] = atc_div(auxCtrl.inSel, coreCtrl.fastMode);
    assign preDiv[1] = atc_div(coreCtrl.inSel, coreCtrl.fastMode);
    assign preEn[0] = auxRunning & auxGateOk;
    assign preEn[1] = coreRunning & coreGateOk;

    // A divisor change can leave the count above the new end; wrap then.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : gPre
            assign preTick[gi] = preEn[gi] &
                (preCnt[gi] >= preDiv[gi] - 10'h001);
            always_ff @(posedge clk_sys or negedge rstSyncN) begin
                if (!rstSyncN) begin
                    preCnt[gi] <= 10'h000;
                end else if (preTick[gi]) begin
                    preCnt[gi] <= 10'h000;
                end else if (preEn[gi]) begin
                    preCnt[gi] <= preCnt[gi] + 10'h001;
                end
            end
        end
    endgenerate

    // Toggle latch edges feed aux counter selections 101..111.
    wire tlRise = coreCtrl.toggleLatch & ~tlPrev;
    wire tlFall = ~coreCtrl.toggleLatch & tlPrev;
    wire dirAny = dirRise | dirFall;
    wire auxAny = auxRise | auxFall;
    wire coreAny = coreRise | coreFall;

    // Core counter selections with bit 2 set are forbidden and never step.
    wire coreTick = atc_tick(coreCtrl.mode, coreCtrl.inSel, preTick[1],
        coreRise, coreFall, dirAny, 1'b0, 1'b0);
    wire auxTick = atc_tick(auxCtrl.mode, auxCtrl.inSel, preTick[0],
        auxRise, auxFall, dirAny, tlRise, tlFall);

    // Mode field and select field are decoded by the mode in force.
    wire auxStep = auxRunning & auxTick;
    wire coreStep = coreRunning & coreTick;

    // Quadrature: a lead of the count input means up, a lag means down.
    // The level flops still hold the old value during an edge pulse, so
    // the new levels are rebuilt from the pulses to judge the phase.
    wire auxNew = auxLvl ^ auxAny;
    wire dirNew = dirLvl ^ dirAny;
    wire coreNew = coreLvl ^ coreAny;
    logic next_auxQuadDown;
    logic next_coreQuadDown;
    assign next_auxQuadDown =
        auxAny ? (auxNew ~^ dirNew) :
        dirAny ? (auxNew ^ dirNew) : auxQuadDown;
    assign next_coreQuadDown =
        coreAny ? (coreNew ~^ dirNew) :
        dirAny ? (coreNew ^ dirNew) : coreQuadDown;

    // Direction: quadrature, external line, or the software bit.
    wire auxDown = auxInc ? next_auxQuadDown :
                   auxCtrl.extDirEn ? dirLvl : auxCtrl.dirBit;
    wire coreDown = coreInc ? next_coreQuadDown :
                    coreCtrl.extDirEn ? dirLvl : coreCtrl.dirBit;

    // Sticky flag causes, and the core wrap that flips the toggle latch.
    wire auxEdgeSet = auxStep & auxCounts;
    wire auxDirSet = auxDown != auxDirNow;
    wire coreWrap = coreStep &
        (coreDown ? coreCnt == ATC_CNT_MIN : coreCnt == ATC_CNT_MAX);

    // Aux control: software value, then hardware sets win over clears.
    atc_aux_ctrl_t next_auxCtrl;
    always_comb begin
        next_auxCtrl = auxCtrl;
        if (wrAuxCtrl) begin
            next_auxCtrl = atc_aux_ctrl_t'(pwdata[15:0] &
                                           ATC_AUX_WMASK);
        end
        next_auxCtrl.rotDir = 1'b0;
        next_auxCtrl.rsvd = 2'h0;
        if (auxEdgeSet) begin
            next_auxCtrl.edgeSeen = 1'b1;
        end
        if (auxDirSet) begin
            next_auxCtrl.dirChange = 1'b1;
        end
    end

    // Core control: an overflow or underflow flips the toggle latch.
    atc_core_ctrl_t next_coreCtrl;
    always_comb begin
        next_coreCtrl = coreCtrl;
        if (wrCoreCtrl) begin
            next_coreCtrl = atc_core_ctrl_t'(pwdata[15:0] & ATC_CORE_WMASK);
        end
        next_coreCtrl.toggleLatch =
            next_coreCtrl.toggleLatch ^ coreWrap;
    end

    // Counters: a software load takes priority over a count step.
    logic [ATC_CNT_W-1:0] next_auxCnt;
    logic [ATC_CNT_W-1:0] next_coreCnt;
    assign next_auxCnt = wrAuxCnt ? pwdata[ATC_CNT_W-1:0] :
        !auxStep ? auxCnt :
        auxDown ? auxCnt - 16'h0001 : auxCnt + 16'h0001;
    assign next_coreCnt = wrCoreCnt ? pwdata[ATC_CNT_W-1:0] :
        !coreStep ? coreCnt :
        coreDown ? coreCnt - 16'h0001 : coreCnt + 16'h0001;

    // State registers.
    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            auxCtrl <= atc_aux_ctrl_t'(ATC_CTRL_RESET);
            coreCtrl <= atc_core_ctrl_t'(ATC_CTRL_RESET);
            auxCnt <= ATC_CNT_RESET;
            coreCnt <= ATC_CNT_RESET;
            auxDirNow <= 1'b0;
            auxQuadDown <= 1'b0;
            coreQuadDown <= 1'b0;
            tlPrev <= 1'b0;
        end else begin
            auxCtrl <= next_auxCtrl;
            coreCtrl <= next_coreCtrl;
            auxCnt <= next_auxCnt;
            coreCnt <= next_coreCnt;
            auxDirNow <= auxDown;
            auxQuadDown <= next_auxQuadDown;
            coreQuadDown <= next_coreQuadDown;
            tlPrev <= coreCtrl.toggleLatch;
        end
    end

    // Read data is built live; bit 14 reports the present direction.
    atc_aux_ctrl_t auxView;
    always_comb begin
        auxView = auxCtrl;
        auxView.rotDir = auxDirNow;
    end

    wire [15:0] readWord =
        hitAuxCtrl ? 16'(auxView) :
        hitCoreCtrl ? 16'(coreCtrl) :
        hitAuxCnt ? auxCnt :
        hitCoreCnt ? coreCnt : 16'h0000;

    // Read data is captured in the setup cycle so it stands as a flop
    // through the access cycle; a count in between is not reflected.
    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= {16'h0000, readWord};
        end
    end

    // Request is raised only while enabled and a flag is set.
    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            auxIrqReq <= 1'b0;
        end else begin
            auxIrqReq <= next_auxCtrl.irqEnable &
                (next_auxCtrl.edgeSeen | next_auxCtrl.dirChange);
        end
    end

endmodule : atc_aux_timer

// ===== test/atc_aux_timer_properties.sv
// Purpose: Port-level assertions for the auxiliary timer.
// Assumes: Pins move no faster than once per sixteen clocks.
// Notes: The interrupt enable is mirrored from bus writes, being hidden.
`timescale 1ns/1ps
module atc_aux_timer_properties
    import atc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ATC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic shared_dir_pin,
    input wire logic t4CountIn,
    input wire logic coreToggleOut,
    input wire logic auxIrqReq
);
    logic enMirror;
    logic wrAux;
    logic wrCore;
    logic rdAux;
    logic togBit;

    // Bus decodes shared by the checks below.
    assign wrAux = psel && penable && pwrite && paddr == ATC_OFF_AUX_CTRL;
    assign wrCore = psel && penable && pwrite && paddr == ATC_OFF_CORE_CTRL;
    assign rdAux = psel && !penable && !pwrite && paddr == ATC_OFF_AUX_CTRL;
    assign togBit = pwdata[10];

    // Copy of the enable bit, updated on the same edge as the block's own.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            enMirror <= 1'b0;
        end else if (wrAux) begin
            enMirror <= pwdata[15];
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_unmapped: assert property (pslverr ==
        (psel && penable && paddr[1:0] != 2'h0))
        else $error("pslverr wrong for address");
    a_upper_zero: assert property (prdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_rsvd_zero: assert property (rdAux |=> prdata[11:10] == 2'h0)
        else $error("reserved bits read nonzero");
    a_irq_enable: assert property (!enMirror |-> !auxIrqReq)
        else $error("request while disabled");
    a_irq_sticky: assert property
        (auxIrqReq && !wrAux |=> auxIrqReq)
        else $error("request dropped without a write");
    a_toggle_write: assert property
        (wrCore |=> coreToggleOut == $past(togBit))
        else $error("toggle latch ignores write");
    a_t4_level: assert property
        ($changed(t4CountIn) |-> t4CountIn == $past(shared_dir_pin, 3))
        else $error("timer 4 input differs from shared pin");
endmodule : atc_aux_timer_properties

bind atc_aux_timer atc_aux_timer_properties props (.clk_sys, .resetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .shared_dir_pin, .t4CountIn, .coreToggleOut, .auxIrqReq);

// ===== test/atc_pin_model.sv
// Purpose: Far-side model of the count, direction and encoder pins.
// Assumes: The bench asks for levels; this model owns the pin wires.
// Notes: The slow setting adds a stage, as a sluggish encoder would.
`timescale 1ns/1ps
module atc_pin_model (
    input wire logic clk_sys,
    input wire logic [2:0] wantLvl,
    input wire logic slow,
    output logic auxCountPin,
    output logic coreCountPin,
    output logic dirPin
);
    logic [2:0] lagLvl;

    // Pins idle low from time zero so the block never sees an unknown.
    initial begin
        lagLvl = 3'h0;
        {dirPin, coreCountPin, auxCountPin} = 3'h0;
    end

    // Requests reach the pins one or two edges later.
    always @(posedge clk_sys) begin
        lagLvl <= wantLvl;
        {dirPin, coreCountPin, auxCountPin} <= slow ? lagLvl : wantLvl;
    end
endmodule : atc_pin_model

// ===== test/aux_timer_with_core_input_select_test.sv
// Purpose: Self-checking bench for the auxiliary timer block.
// Assumes: Zero wait-state APB; pins move only through the pin model.
// Notes: Expected counts come from an integer model of the edge rules.
`timescale 1ns/1ps
module aux_timer_with_core_input_select_test
    import atc_pkg::*;
;
    logic clk_sys;
    logic resetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ATC_AW-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic auxPin;
    logic corePin;
    logic dirPin;
    logic t4CountIn;
    logic coreToggleOut;
    logic auxIrqReq;
    logic [2:0] want;
    logic slow;
    logic [31:0] rd;
    logic err;
    logic [15:0] lfsr;
    int nFail;
    int checkCount;
    int expCnt;
    int lastDown;

    atc_aux_timer uut (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .aux_count_in(auxPin),
        .core_count_in(corePin), .shared_dir_pin(dirPin), .t4CountIn,
        .coreToggleOut, .auxIrqReq);
    atc_pin_model pins (.clk_sys, .wantLvl(want), .slow,
        .auxCountPin(auxPin), .coreCountPin(corePin), .dirPin);

    // Free-running 200 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    function automatic logic [15:0] lfsrNext(input logic [15:0] s);
        lfsrNext = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsrNext

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            nFail++;
        end
    endtask : chk

    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic [3:0] a, input logic w,
                       input logic [15:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 16'h0000);
        chk(rd, exp);
    endtask : rdc

    task automatic idle(input int c);
        repeat (c) @(posedge clk_sys);
    endtask : idle

    // Pins are held twenty clocks, longer than the slow sample period.
    task automatic setPin(input int idx, input logic lvl);
        want[idx] <= lvl;
        idle(20);
    endtask : setPin

    task automatic pulse(input int idx);
        setPin(idx, 1'b1);
        setPin(idx, 1'b0);
    endtask : pulse

    task automatic tallyAndFinish();
        $display("comparisons %0d mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tallyAndFinish

    // Watchdog sized well above the few thousand cycles the tests need.
    initial begin
        idle(50000);
        nFail++;
        tallyAndFinish();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        want = 3'h0;
        slow = 1'b0;
        nFail = 0;
        checkCount = 0;
        lfsr = 16'h8197;
        resetn = 1'b0;
        idle(10);
        resetn <= 1'b1;
        idle(3);
        // All registers start at zero; a hole refuses with an error.
        for (int i = 0; i < 4; i++) rdc(4'(4 * i), 32'h0);
        apb(4'h6, 1'b1, 16'hFFFF);
        chk({31'h0, err}, 32'h1);
        apb(ATC_OFF_AUX_CTRL, 1'b1, 16'h3C00);
        rdc(ATC_OFF_AUX_CTRL, 32'h3000);
        $display("registers done");
        // Every counter selection, with a random count of pulses each.
        for (int s = 0; s < 8; s++) begin
            int n;
            int e;
            lfsr = lfsrNext(lfsr);
            n = lfsr[1:0] + 1;
            e = (s % 4 == 0) ? 0 : (s % 4 == 3 ? 2 * n : n);
            apb(ATC_OFF_AUX_CNT, 1'b1, 16'h0000);
            apb(ATC_OFF_AUX_CTRL, 1'b1, 16'h0048 | 16'(s) | 16'(s % 2) << 7);
            for (int k = 0; k < n; k++) begin
                if (s < 4) begin
                    pulse(0);
                end else begin
                    apb(ATC_OFF_CORE_CTRL, 1'b1, 16'h0400);
                    idle(4);
                    apb(ATC_OFF_CORE_CTRL, 1'b1, 16'h0000);
                    idle(4);
                end
            end
            rdc(ATC_OFF_AUX_CNT, {16'h0, 16'(s % 2 ? -e : e)});
            apb(ATC_OFF_AUX_CTRL, 1'b0, 16'h0000);
            chk(rd & 32'h5000, {17'h0, 1'(s % 2), 1'b0, 1'(e > 0), 12'h0});
        end
        $display("counter selections done");
        // Own run bit off holds; the remote bit hands run to the core.
        apb(ATC_OFF_AUX_CNT, 1'b1, 16'h0000);
        apb(ATC_OFF_AUX_CTRL, 1'b1, 16'h0009);
        pulse(0);
        apb(ATC_OFF_AUX_CTRL, 1'b1, 16'h0209);
        apb(ATC_OFF_CORE_CTRL, 1'b1, 16'h0048);
        pulse(0);
        pulse(1);
        apb(ATC_OFF_CORE_CTRL, 1'b1, 16'h0049);
        pulse(1);
        apb(ATC_OFF_CORE_CTRL, 1'b1, 16'h0000);
        pulse(0);
        rdc(ATC_OFF_AUX_CNT, 32'h1);
        rdc(ATC_OFF_CORE_CNT, 32'h1);
        // A core overflow from the top value flips the toggle latch.
        apb(ATC_OFF_CORE_CNT, 1'b1, 16'hFFFF);
        apb(ATC_OFF_CORE_CTRL, 1'b1, 16'h0049);
        pulse(1);
        chk({31'h0, coreToggleOut}, 32'h1);
        apb(ATC_OFF_CORE_CTRL, 1'b1, 16'h0000);
        $display("run control done");
        // The request needs a flag and the enable, and drops on clearing.
        apb(ATC_OFF_AUX_CTRL, 1'b1, 16'h1000);
        idle(3);
        chk({31'h0, auxIrqReq}, 32'h0);
        apb(ATC_OFF_AUX_CTRL, 1'b1, 16'h9000);
        idle(3);
        chk({31'h0, auxIrqReq}, 32'h1);
        apb(ATC_OFF_AUX_CTRL, 1'b1, 16'h8000);
        idle(3);
        chk({31'h0, auxIrqReq}, 32'h0);
        $display("interrupt done");
        // The shared pin steers direction and also feeds timer 4.
        apb(ATC_OFF_AUX_CNT, 1'b1, 16'h0000);
        apb(ATC_OFF_AUX_CTRL, 1'b1, 16'h0149);
        setPin(2, 1'b1);
        chk({31'h0, t4CountIn}, 32'h1);
        pulse(0);
        rdc(ATC_OFF_AUX_CNT, 32'hFFFF);
        apb(ATC_OFF_AUX_CTRL, 1'b0, 16'h0000);
        chk(rd & 32'h7000, 32'h7000);
        setPin(2, 1'b0);
        $display("external direction done");
        // Timer mode over a 384-cycle window: divisor 4 fast, 16 slow.
        // The prescaler phase is unknown, so two reads bracket the window.
        for (int f = 0; f < 2; f++) begin
            int dv;
            dv = f ? 4 : 16;
            apb(ATC_OFF_CORE_CTRL, 1'b1, f ? 16'h0800 : 16'h0000);
            apb(ATC_OFF_AUX_CNT, 1'b1, 16'h0000);
            apb(ATC_OFF_AUX_CTRL, 1'b1, f ? 16'h0040 : 16'h0041);
            apb(ATC_OFF_AUX_CNT, 1'b0, 16'h0000);
            expCnt = rd[15:0];
            idle(381);
            rdc(ATC_OFF_AUX_CNT, 32'(expCnt + 384 / dv));
            apb(ATC_OFF_AUX_CTRL, 1'b1, 16'h0000);
        end
        $display("prescaler done");
        // Random quadrature walk with the far side lagging.
        slow <= 1'b1;
        apb(ATC_OFF_AUX_CNT, 1'b1, 16'h0000);
        apb(ATC_OFF_AUX_CTRL, 1'b1, 16'h007B);
        expCnt = 0;
        for (int k = 0; k < 12; k++) begin
            int idx;
            lfsr = lfsrNext(lfsr);
            idx = lfsr[0] ? 2 : 0;
            lastDown = idx == 0 ? (!want[0]) == want[2] : want[0] != !want[2];
            expCnt += lastDown ? -1 : 1;
            setPin(idx, !want[idx]);
        end
        rdc(ATC_OFF_AUX_CNT, {16'h0, 16'(expCnt)});
        apb(ATC_OFF_AUX_CTRL, 1'b0, 16'h0000);
        chk(rd & 32'h4000, 32'(lastDown) << 14);
        $display("incremental done");
        tallyAndFinish();
    end
endmodule : aux_timer_with_core_input_select_test
